// ---- hw/adcs_audio_ctrl.sv ----
// Purpose: control word port, settings and audio input of a stereo DAC
// Assumes: all pins are asynchronous to clk; clk runs at 125 MHz
// Notes: the analog path sits outside; this block hands it settings
// Notes: and the samples that are to be heard
`timescale 1ns/1ps
module adcs_audio_ctrl (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  ctl_sclk,
  input  wire logic                  ctl_sdata,
  input  wire logic                  ctl_enable,
  input  wire logic                  aud_bclk_i,
  output logic                       aud_bclk_o,
  output logic                       aud_bclk_oe,
  input  wire logic                  aud_ws_i,
  output logic                       aud_ws_o,
  output logic                       aud_ws_oe,
  input  wire logic                  aud_data,
  output adcs_pkg::adcs_cfg_type     cfg,
  output logic                       power_off_mode,
  output logic [31:0]                left_phone_out,
  output logic [31:0]                right_phone_out,
  output logic                       sample_stb
);
  logic [adcs_pkg::PIN_COUNT-1:0] pin_raw_w;
  logic [adcs_pkg::PIN_COUNT-1:0] pin_flt_w;
  logic [15:0]                    word_w;
  logic                           wstb_w;
  adcs_pkg::adcs_sample_type      smp_w;
  logic                           smp_stb_w;
  adcs_pkg::adcs_cfg_type         cfg_q;
  adcs_pkg::adcs_cfg_type         cfg_d;
  adcs_pkg::adcs_mode_type        tgt_mode_w;
  logic [4:0]                     tgt_vol_w;
  logic                           gate_on_w;
  logic                           tgt_down_w;
  logic                           clk_on_w;
  logic                           clear_w;
  logic                           active_w;
  logic                           mode_go_w;
  logic                           vol_go_w;
  logic                           left_in_w;
  logic                           zc_hit_w;
  logic                           zc_evt_q;
  logic [31:0]                    prev_left_q;
  logic                           power_off_q;
  logic [31:0]                    left_q;
  logic [31:0]                    right_q;
  logic                           stb_q;

  function automatic adcs_pkg::adcs_mode_type mode_of(input logic [1:0] b);
    unique case (b)
      2'b00: mode_of = adcs_pkg::MODE_OFF;
      2'b01: mode_of = adcs_pkg::MODE_STANDBY;
      2'b10: mode_of = adcs_pkg::MODE_MUTE;
      2'b11: mode_of = adcs_pkg::MODE_ACTIVE;
    endcase
  endfunction

  function automatic logic sign_of(input logic [31:0] d, input logic wide);
    sign_of = wide ? d[31] : d[15];
  endfunction

  // three-flop filters: a level is taken once the last two agree
  assign pin_raw_w = {aud_data, aud_ws_i, aud_bclk_i,
                      ctl_enable, ctl_sdata, ctl_sclk};

  generate
    for (genvar g = 0; g < adcs_pkg::PIN_COUNT; g++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic flt_q;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          flt_q <= 1'b0;
        end else begin
          s1_q <= pin_raw_w[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            flt_q <= s3_q;
          end
        end
      end
      assign pin_flt_w[g] = flt_q;
    end
  endgenerate

  adcs_ctl_shift u_ctl (
    .clk      (clk),
    .nrst     (nrst),
    .sclk     (pin_flt_w[adcs_pkg::PIN_SCLK]),
    .sdata    (pin_flt_w[adcs_pkg::PIN_SDATA]),
    .enable   (pin_flt_w[adcs_pkg::PIN_ENABLE]),
    .word     (word_w),
    .word_stb (wstb_w)
  );

  adcs_i2s_port u_i2s (
    .clk     (clk),
    .nrst    (nrst),
    .run     (clk_on_w),
    .clear   (clear_w),
    .master  (cfg_q.master),
    .wide    (cfg_q.wide),
    .bclk    (pin_flt_w[adcs_pkg::PIN_BCLK]),
    .ws      (pin_flt_w[adcs_pkg::PIN_WS]),
    .adata   (pin_flt_w[adcs_pkg::PIN_ADATA]),
    .bclk_o  (aud_bclk_o),
    .bclk_oe (aud_bclk_oe),
    .ws_o    (aud_ws_o),
    .ws_oe   (aud_ws_oe),
    .smp     (smp_w),
    .smp_stb (smp_stb_w)
  );

  // settings requested by the latest control word
  assign tgt_mode_w = mode_of(word_w[adcs_pkg::BIT_MODE_HI:
                                     adcs_pkg::BIT_MODE_LO]);
  assign tgt_vol_w = word_w[adcs_pkg::BIT_VOL_HI:adcs_pkg::BIT_VOL_LO];
  assign gate_on_w = ~word_w[adcs_pkg::BIT_ZC_OFF];
  assign tgt_down_w = (tgt_mode_w == adcs_pkg::MODE_OFF) |
                      (tgt_mode_w == adcs_pkg::MODE_STANDBY);

  // clocks live in mute and active only; off also drops link state
  assign clk_on_w = cfg_q.run & ((cfg_q.mode == adcs_pkg::MODE_MUTE) |
                                 (cfg_q.mode == adcs_pkg::MODE_ACTIVE));
  assign clear_w = ~cfg_q.run | (cfg_q.mode == adcs_pkg::MODE_OFF);
  assign active_w = cfg_q.run & (cfg_q.mode == adcs_pkg::MODE_ACTIVE);

  // with no clocks there can be no crossing, so mode changes do not wait for one
  assign mode_go_w = (tgt_mode_w != cfg_q.mode) &
                     (~tgt_down_w | ~gate_on_w | zc_evt_q | ~clk_on_w);
  assign vol_go_w = (tgt_vol_w != cfg_q.volume) &
                    (~gate_on_w | zc_evt_q);

  assign cfg_d = '{
    mode:              mode_go_w ? tgt_mode_w : cfg_q.mode,
    master:            word_w[adcs_pkg::BIT_ROLE],
    wide:              word_w[adcs_pkg::BIT_WIDE],
    zero_cross_gate:   gate_on_w,
    volume:            vol_go_w ? tgt_vol_w : cfg_q.volume,
    bias_charge_speed: word_w[adcs_pkg::BIT_CHARGE],
    run:               word_w[adcs_pkg::BIT_RUN]
  };

  // crossing: left sample is zero or its sign differs from the last
  assign left_in_w = smp_stb_w & ~smp_w.right;
  assign zc_hit_w = left_in_w &
                    ((smp_w.data == 32'h0000_0000) |
                     (sign_of(smp_w.data, cfg_q.wide) !=
                      sign_of(prev_left_q, cfg_q.wide)));

  assign cfg = cfg_q;
  assign power_off_mode = power_off_q;
  assign left_phone_out = left_q;
  assign right_phone_out = right_q;
  assign sample_stb = stb_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q       <= adcs_pkg::CFG_RESET;
      power_off_q <= 1'b1;
    end else begin
      cfg_q       <= cfg_d;
      power_off_q <= cfg_d.mode == adcs_pkg::MODE_OFF;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zc_evt_q    <= 1'b0;
      prev_left_q <= 32'h0000_0000;
    end else begin
      zc_evt_q <= zc_hit_w;
      if (left_in_w) begin
        prev_left_q <= smp_w.data;
      end
    end
  end

  // mute and every non-active mode silence the outputs at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      left_q  <= 32'h0000_0000;
      right_q <= 32'h0000_0000;
      stb_q   <= 1'b0;
    end else begin
      stb_q <= smp_stb_w & active_w;
      if (!active_w) begin
        left_q  <= 32'h0000_0000;
        right_q <= 32'h0000_0000;
      end else if (smp_stb_w && !smp_w.right) begin
        left_q <= smp_w.data;
      end else if (smp_stb_w) begin
        right_q <= smp_w.data;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_mode_direct: assert property (
    wstb_w && word_w[adcs_pkg::BIT_ZC_OFF] |=>
      cfg_q.mode == mode_of(word_w[adcs_pkg::BIT_MODE_HI:
                                   adcs_pkg::BIT_MODE_LO]))
    else $error("ungated mode not applied one cycle after word");
  a_vol_direct: assert property (
    wstb_w && word_w[adcs_pkg::BIT_ZC_OFF] |=>
      cfg_q.volume == word_w[adcs_pkg::BIT_VOL_HI:adcs_pkg::BIT_VOL_LO])
    else $error("ungated volume not applied one cycle after word");
  a_vol_gated: assert property (
    $changed(cfg_q.volume) |->
      $past(zc_evt_q) || $past(word_w[adcs_pkg::BIT_ZC_OFF]))
    else $error("volume stepped without a zero crossing");
  a_down_gated: assert property (
    $changed(cfg_q.mode) &&
    (cfg_q.mode == adcs_pkg::MODE_OFF ||
     cfg_q.mode == adcs_pkg::MODE_STANDBY) |->
      $past(zc_evt_q) || $past(word_w[adcs_pkg::BIT_ZC_OFF]) ||
      !$past(clk_on_w))
    else $error("power down taken without a zero crossing");
  a_standby_still: assert property (
    cfg_q.mode == adcs_pkg::MODE_STANDBY ##1
    cfg_q.mode == adcs_pkg::MODE_STANDBY |->
      $stable(aud_bclk_o) && !aud_bclk_oe)
    else $error("bit clock moved in standby");
  a_mute_drives: assert property (
    (cfg_q.master && clk_on_w)[*2] |-> aud_bclk_oe && aud_ws_oe)
    else $error("master stopped driving clocks while running");
  a_slave_quiet: assert property (
    (!cfg_q.master)[*2] |-> !aud_bclk_oe && !aud_ws_oe)
    else $error("slave drives the audio clocks");
  a_role_bits: assert property (
    wstb_w |=> cfg_q.master == word_w[adcs_pkg::BIT_ROLE] &&
               cfg_q.wide == word_w[adcs_pkg::BIT_WIDE])
    else $error("role or word size not taken from the word");
  a_reset_silent: assert property (
    !cfg_q.run |=> left_q == 32'h0000_0000 && right_q == 32'h0000_0000)
    else $error("output not silent while converter held in reset");
  a_charge_bit: assert property (
    wstb_w |=> cfg_q.bias_charge_speed == word_w[adcs_pkg::BIT_CHARGE])
    else $error("charge speed not taken from the word");
endmodule

// ---- hw/adcs_pkg.sv ----
// Purpose: shared constants and types of the DAC control and audio port
// Assumes: clk runs at 125 MHz
// Notes: control word fields are bit positions within the 16-bit word
package adcs_pkg;
  localparam int CW_BITS = 16;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [4:0] CW_LAST = 5'h0f;
  localparam logic [4:0] CW_FULL = 5'h10;
  localparam int BIT_RUN = 0;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_MODE_HI = 2;
  localparam int BIT_ROLE = 3;
  localparam int BIT_WIDE = 4;
  localparam int BIT_ZC_OFF = 6;
  localparam int BIT_VOL_LO = 7;
  localparam int BIT_VOL_HI = 11;
  localparam int BIT_CHARGE = 12;
  // order of the filtered pin vector
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_ENABLE = 2;
  localparam int PIN_BCLK = 3;
  localparam int PIN_WS = 4;
  localparam int PIN_ADATA = 5;
  localparam int PIN_COUNT = 6;
  localparam logic [5:0] NARROW_BITS = 6'h10;
  localparam logic [5:0] WIDE_BITS = 6'h20;
  localparam logic [5:0] BCNT_IDLE = 6'h3f;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BCLK_HALF_NS = 328;
  localparam int BCLK_HALF_CYC = BCLK_HALF_NS / CLK_PERIOD_NS;
  localparam logic [5:0] BCLK_HALF_LAST = 6'(BCLK_HALF_CYC - 1);

  typedef enum logic [3:0] {
    MODE_OFF     = 4'h1,
    MODE_STANDBY = 4'h2,
    MODE_MUTE    = 4'h4,
    MODE_ACTIVE  = 4'h8
  } adcs_mode_type;

  typedef struct packed {
    adcs_mode_type mode;
    logic          master;
    logic          wide;
    logic          zero_cross_gate;
    logic [4:0]    volume;
    logic          bias_charge_speed;
    logic          run;
  } adcs_cfg_type;

  localparam adcs_cfg_type CFG_RESET = '{mode: MODE_OFF, volume: 5'h00,
                                         default: 1'b0};

  typedef struct packed {
    logic        right;
    logic [31:0] data;
  } adcs_sample_type;
endpackage

// ---- hw/adcs_ctl_shift.sv ----
// Purpose: assembles 16-bit control words from the filtered serial pins
// Assumes: inputs already synchronised to clk
// Notes: word holds the last complete word; word_stb marks its arrival
`timescale 1ns/1ps
module adcs_ctl_shift (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        enable,
  output logic [15:0]      word,
  output logic             word_stb
);
  logic        sclk_d_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic [15:0] word_q;
  logic        stb_q;
  logic        rise_w;
  logic        take_w;
  logic [15:0] sh_d;

  assign rise_w = enable & sclk & ~sclk_d_q;
  assign take_w = rise_w & (cnt_q != adcs_pkg::CW_FULL);
  assign sh_d = {sdata, sh_q[15:1]};
  assign word = word_q;
  assign word_stb = stb_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_q <= 1'b0;
      cnt_q    <= 5'h00;
      sh_q     <= 16'h0000;
      word_q   <= adcs_pkg::CW_RESET;
      stb_q    <= 1'b0;
    end else begin
      sclk_d_q <= sclk;
      stb_q    <= 1'b0;
      if (!enable) begin
        cnt_q <= 5'h00;
      end else if (take_w) begin
        cnt_q <= cnt_q + 5'h01;
        sh_q  <= sh_d;
        if (cnt_q == adcs_pkg::CW_LAST) begin
          word_q <= sh_d;
          stb_q  <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_word_count: assert property (
    stb_q |-> $past(take_w) && $past(cnt_q) == adcs_pkg::CW_LAST)
    else $error("word latched at wrong clock count");
  a_abort_clear: assert property (
    !enable |=> cnt_q == 5'h00 && !stb_q)
    else $error("partial word survived enable low");
  a_lsb_first: assert property (
    stb_q |-> word_q[15] == $past(sdata) && word_q[14:0] == $past(sh_q[15:1]))
    else $error("control word not assembled lsb first");
  a_extra_ignored: assert property (
    enable && cnt_q == adcs_pkg::CW_FULL |=> $stable(word_q) && !stb_q)
    else $error("clock beyond sixteenth changed the word");
endmodule

// ---- hw/adcs_i2s_port.sv ----
// Purpose: audio serial receiver with optional bit clock generation
// Assumes: slave pins already synchronised to clk
// Notes: all link events are taken at bit clock rising edges
`timescale 1ns/1ps
module adcs_i2s_port (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    run,
  input  wire logic                    clear,
  input  wire logic                    master,
  input  wire logic                    wide,
  input  wire logic                    bclk,
  input  wire logic                    ws,
  input  wire logic                    adata,
  output logic                         bclk_o,
  output logic                         bclk_oe,
  output logic                         ws_o,
  output logic                         ws_oe,
  output adcs_pkg::adcs_sample_type    smp,
  output logic                         smp_stb
);
  logic [5:0]  half_q;
  logic        bclk_q;
  logic [6:0]  fbit_q;
  logic        mws_q;
  logic        oe_q;
  logic        bclk_d_q;
  logic        ws_d_q;
  logic        data_d_q;
  logic        wsl_q;
  logic [5:0]  bcnt_q;
  logic [31:0] sh_q;
  adcs_pkg::adcs_sample_type smp_q;
  logic        stb_q;
  logic [5:0]  nbits_w;
  logic [5:0]  wlast_w;
  logic [6:0]  flast_w;
  logic        tick_w;
  logic        grise_w;
  logic        rise_w;
  logic        ws_pre_w;
  logic        chg_w;
  logic        shift_w;
  logic        emit_w;
  logic [31:0] sh_d_w;

  assign nbits_w = wide ? adcs_pkg::WIDE_BITS : adcs_pkg::NARROW_BITS;
  assign wlast_w = nbits_w - 6'h01;
  assign flast_w = {nbits_w, 1'b0} - 7'h01;
  assign tick_w = run & master & (half_q == adcs_pkg::BCLK_HALF_LAST);
  assign grise_w = tick_w & ~bclk_q;
  assign rise_w = grise_w | (run & ~master & bclk & ~bclk_d_q);
  assign ws_pre_w = master ? mws_q : ws_d_q;
  assign chg_w = rise_w & (ws_pre_w != wsl_q);
  assign shift_w = rise_w & (bcnt_q < nbits_w);
  assign emit_w = shift_w & (bcnt_q == wlast_w);
  assign sh_d_w = {sh_q[30:0], data_d_q};
  assign bclk_o = bclk_q;
  assign bclk_oe = oe_q;
  assign ws_o = mws_q;
  assign ws_oe = oe_q;
  assign smp = smp_q;
  assign smp_stb = stb_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 6'h00;
      bclk_q <= 1'b0;
      fbit_q <= 7'h00;
      mws_q  <= 1'b0;
    end else if (clear) begin
      half_q <= 6'h00;
      bclk_q <= 1'b0;
      fbit_q <= 7'h00;
      mws_q  <= 1'b0;
    end else if (run && master) begin
      half_q <= tick_w ? 6'h00 : half_q + 6'h01;
      bclk_q <= bclk_q ^ tick_w;
      if (grise_w) begin
        fbit_q <= (fbit_q == flast_w) ? 7'h00 : fbit_q + 7'h01;
        if (fbit_q == flast_w || fbit_q == {1'b0, wlast_w}) begin
          mws_q <= ~mws_q;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_q     <= 1'b0;
      bclk_d_q <= 1'b0;
      ws_d_q   <= 1'b0;
      data_d_q <= 1'b0;
    end else begin
      oe_q     <= run & master;
      bclk_d_q <= bclk;
      ws_d_q   <= ws;
      data_d_q <= adata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wsl_q  <= 1'b0;
      bcnt_q <= adcs_pkg::BCNT_IDLE;
      sh_q   <= 32'h0000_0000;
    end else if (clear) begin
      wsl_q  <= 1'b0;
      bcnt_q <= adcs_pkg::BCNT_IDLE;
      sh_q   <= 32'h0000_0000;
    end else if (rise_w) begin
      wsl_q  <= ws_pre_w;
      bcnt_q <= chg_w ? 6'h00 : bcnt_q + {5'h00, shift_w};
      if (shift_w) begin
        sh_q <= sh_d_w;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smp_q <= '0;
      stb_q <= 1'b0;
    end else begin
      stb_q <= emit_w;
      if (emit_w) begin
        smp_q.right <= wsl_q;
        smp_q.data  <= wide ? sh_d_w : {16'h0000, sh_d_w[15:0]};
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ws_on_rise: assert property (
    $changed(mws_q) && !$past(clear) |-> $rose(bclk_q))
    else $error("word select moved off a bit clock rise");
  a_frame_len: assert property (
    $changed(mws_q) && !$past(clear) |->
      $past(fbit_q) == $past(flast_w) ||
      $past(fbit_q) == {1'b0, $past(wlast_w)})
    else $error("word select period not 32 or 64 bit clocks");
  a_word_bits: assert property (
    stb_q |-> $past(bcnt_q) == $past(wlast_w) && $past(rise_w))
    else $error("sample emitted at wrong bit count");
  a_left_low: assert property (
    stb_q |-> smp_q.right == $past(wsl_q))
    else $error("channel flag does not follow word select");
endmodule

// ---- verification/adcs_host_model.sv ----
// Purpose: host controller and audio source on the block's pins
// Assumes: pins change just after clk rising edges
// Notes: control clock idles low; released data shows inverted level
`timescale 1ns/1ps
module adcs_host_model (
  input  wire logic clk,
  output logic      sclk,
  output logic      sdata,
  output logic      enable,
  output logic      bclk,
  output logic      ws,
  output logic      adata
);
  initial {sclk, sdata, enable, bclk, ws, adata} = 6'h02;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // n above 16 sends extra clocks, below 16 aborts
  task automatic send_word(input logic [15:0] w, input int n);
    tick(1);
    enable <= 1'b1;
    tick(3);
    for (int i = 0; i < n; i++) begin
      sdata <= w[i % 16];
      tick(3);
      sclk <= 1'b1;
      tick(13);
      sclk <= 1'b0;
      tick(10);
    end
    tick(3);
    enable <= 1'b0;
    sdata <= ~sdata;
    tick(6);
  endtask
  // one 80 ns bit period; values change just after the rise
  task automatic abit(input logic w, input logic d);
    tick(1);
    bclk <= 1'b0;
    tick(5);
    bclk <= 1'b1;
    tick(1);
    ws <= w;
    adata <= d;
    tick(3);
  endtask
  task automatic frame(input logic [15:0] l, input logic [15:0] r);
    for (int p = -2; p < 32; p++)
      abit((p >= 15 && p < 31) || p < -1,
           p < 0 ? 1'b0 : (p < 16 ? l[15 - p] : r[31 - p]));
    abit(1'b0, 1'b0);
  endtask
endmodule

// ---- verification/tb_adcs_audio_ctrl.sv ----
// Purpose: self-checking bench of the control port and audio input
// Assumes: host model drives the control and audio pins; the bench drives clk and nrst
// Notes: shared pins resolve from the block's output enables
`timescale 1ns/1ps
module tb_adcs_audio_ctrl;
  logic                   clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   sclk, sdata, en, bclk, ws, adata;
  logic                   bclk_o, bclk_oe, ws_o, ws_oe, pwr_off, stb;
  logic [31:0]            left, right;
  adcs_pkg::adcs_cfg_type cfg;
  int                     n_errors = 0;
  int                     num_checks = 0;
  int                     g;
  int                     n_stb = 0;
  logic [4:0]             vt [4] = '{5'h00, 5'h15, 5'h0a, 5'h1f};
  always #4 clk = ~clk;
  // counts sample strobes for the audio scenario
  always @(posedge clk) begin
    if (stb === 1'b1) n_stb++;
  end
  adcs_host_model host (.clk(clk), .sclk(sclk), .sdata(sdata),
    .enable(en), .bclk(bclk), .ws(ws), .adata(adata));
  adcs_audio_ctrl dut (.clk(clk), .nrst(nrst), .ctl_sclk(sclk),
    .ctl_sdata(sdata), .ctl_enable(en),
    .aud_bclk_i(bclk_oe ? bclk_o : bclk), .aud_bclk_o(bclk_o),
    .aud_bclk_oe(bclk_oe), .aud_ws_i(ws_oe ? ws_o : ws), .aud_ws_o(ws_o),
    .aud_ws_oe(ws_oe), .aud_data(adata), .cfg(cfg),
    .power_off_mode(pwr_off), .left_phone_out(left),
    .right_phone_out(right), .sample_stb(stb));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // wide follows x, charge speed the inverse of x
  function automatic logic [15:0] cw(input logic [1:0] m, input logic ms,
      input logic x, input logic [4:0] v, input logic z);
    return {3'h0, ~x, v, z, 1'b1, x, ms, m, 1'b1};
  endfunction
  function automatic logic [13:0] ecfg(input logic [15:0] w);
    return {4'h1 << w[2:1], w[3], w[4], ~w[6], w[11:7], w[12], w[0]};
  endfunction
  // clocks between two toggles of a driven clock, lim if none
  task automatic gap(input logic ws_sel, input int lim);
    logic p;
    for (int k = 0; k < 2; k++) begin
      p = ws_sel ? ws_o : bclk_o;
      g = 0;
      while ((ws_sel ? ws_o : bclk_o) === p && g < lim) begin
        tick(1);
        g++;
      end
    end
  endtask
  task automatic t_reset;
    chk("cfg", 32'(ecfg(16'h0000)), 32'(cfg));
    chk("power_off", 32'h1, 32'(pwr_off));
    chk("oe", 32'h0, {30'h0, bclk_oe, ws_oe});
    $display("reset test done");
  endtask
  task automatic t_fields;
    logic [15:0] w;
    for (int m = 0; m < 4; m++) begin
      w = cw(2'(m), 1'b0, m[0], vt[m], 1'b1);
      host.send_word(w, 16);
      chk("cfg", 32'(ecfg(w)), 32'(cfg));
      chk("power_off", 32'(m == 0), 32'(pwr_off));
    end
    w = cw(2'h3, 1'b0, 1'b0, 5'h11, 1'b1);
    host.send_word(w, 18);
    chk("cfg extra", 32'(ecfg(w)), 32'(cfg));
    host.send_word(cw(2'h0, 1'b1, 1'b1, 5'h03, 1'b1), 10);
    chk("cfg abort", 32'(ecfg(w)), 32'(cfg));
    $display("field test done");
  endtask
  task automatic t_audio;
    n_stb = 0;
    host.frame(16'ha5c3, 16'h3c5a);
    tick(10);
    chk("samples", 32'd2, 32'(n_stb));
    chk("left", 32'h0000a5c3, left);
    chk("right", 32'h00003c5a, right);
    chk("oe slave", 32'h0, {30'h0, bclk_oe, ws_oe});
    host.send_word(cw(2'h3, 1'b0, 1'b0, 5'h04, 1'b0), 16);
    chk("gate", 32'h1, 32'(cfg.zero_cross_gate));
    chk("vol held", 32'h11, 32'(cfg.volume));
    host.frame(16'h0000, 16'h1234);
    tick(10);
    chk("vol at zero", 32'h04, 32'(cfg.volume));
    $display("audio test done");
  endtask
  task automatic t_master;
    host.send_word(cw(2'h3, 1'b1, 1'b0, 5'h04, 1'b1), 16);
    chk("oe master", 32'h3, {30'h0, bclk_oe, ws_oe});
    gap(1'b0, 200);
    chk("half period", adcs_pkg::BCLK_HALF_CYC, g);
    gap(1'b1, 3000);
    chk("ws half", 32 * adcs_pkg::BCLK_HALF_CYC, g);
    host.send_word(cw(2'h2, 1'b1, 1'b0, 5'h04, 1'b1), 16);
    gap(1'b0, 200);
    chk("mute clock", adcs_pkg::BCLK_HALF_CYC, g);
    host.send_word(cw(2'h2, 1'b1, 1'b1, 5'h04, 1'b1), 16);
    gap(1'b1, 3000);
    chk("ws half wide", 64 * adcs_pkg::BCLK_HALF_CYC, g);
    host.send_word(cw(2'h1, 1'b1, 1'b0, 5'h04, 1'b1), 16);
    tick(50);
    gap(1'b0, 200);
    chk("standby clock", 32'd200, g);
    $display("master test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    tick(6);
    t_reset;
    t_fields;
    t_audio;
    t_master;
    report_and_stop;
  end
endmodule
